//--- rtl/ubl_pkg.sv
/*
 package for the baud tick generator and loopback block: register
 indices, field positions, reset values and generator widths.
 assumes nothing of its surroundings.
*/
package ubl_pkg;
   // register bus geometry
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   // register indices, one byte register per index
   localparam logic [2:0] ADDR_MODEM_CTRL = 3'h0;
   localparam logic [2:0] ADDR_SAMPLE_CLK = 3'h1;
   localparam logic [2:0] ADDR_DIV_LOW = 3'h2;
   localparam logic [2:0] ADDR_DIV_HIGH = 3'h3;
   localparam logic [2:0] ADDR_PRE_EXP = 3'h4;
   localparam logic [2:0] ADDR_PRE_OFS = 3'h5;
   localparam logic [2:0] ADDR_STATUS = 3'h6;
   localparam logic [2:0] ADDR_TICK_CNT = 3'h7;
   // field positions and widths
   localparam int LOOP_BIT = 4;
   localparam int SCLK_W = 4;
   localparam int EXP_W = 2;
   localparam int OFS_W = 3;
   localparam int SC_W = 5;
   localparam int DIV_W = 16;
   localparam int PRE_W = 8;
   localparam int PERIOD_W = DIV_W + PRE_W;
   localparam int ST_LOOP_BIT = 0;
   localparam int ST_DIVZ_BIT = 1;
   // sample clock count is this base minus the register value
   localparam logic [SC_W-1:0] SC_BASE = 5'h10;
   // reset values
   localparam logic [7:0] RST_MODEM_CTRL = 8'h00;
   localparam logic [SCLK_W-1:0] RST_SAMPLE_CLK = 4'h0;
   localparam logic [7:0] RST_DIV_LOW = 8'h00;
   localparam logic [7:0] RST_DIV_HIGH = 8'h00;
   localparam logic [EXP_W-1:0] RST_PRE_EXP = 2'h1;
   localparam logic [OFS_W-1:0] RST_PRE_OFS = 3'h0;
   // line idle level driven on the pin while looped back
   localparam logic LINE_IDLE = 1'b1;
endpackage : ubl_pkg

//--- rtl/ubl_sync2.sv
/*
 two flip-flop synchroniser for one level from outside the clock domain.
 assumes the input is a slow level such as a serial line.
*/
`timescale 1ns/1ps
module ubl_sync2 import ubl_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // level in and out
   input wire logic async_in,
   output logic sync_out
);
   logic meta_ff;
   logic sync_ff;
   logic nxt_meta;

   always_comb
   begin
      nxt_meta = async_in;
   end

   // idle line is high, so reset to the idle level
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_ff <= LINE_IDLE;
         sync_ff <= LINE_IDLE;
      end
      else
      begin
         meta_ff <= nxt_meta;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule : ubl_sync2

//--- rtl/ubl_tick_gen.sv
/*
 cascaded prescale and divisor counters giving one baud tick every
 divisor times prescaler clocks.
 assumes reload is a one-cycle pulse raised after the settings change.
*/
`timescale 1ns/1ps
module ubl_tick_gen import ubl_pkg::*;
#(
   parameter int DW = DIV_W,
   parameter int PW = PRE_W
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // settings
   input wire logic reload,
   input wire logic [DW-1:0] divisor,
   input wire logic [PW-1:0] prescaler,
   // tick out
   output logic tick
);
   logic [PW-1:0] pre_cnt_ff;
   logic [DW-1:0] div_cnt_ff;
   logic tick_ff;
   logic [PW-1:0] nxt_pre_cnt;
   logic [DW-1:0] nxt_div_cnt;
   logic nxt_tick;

   if (DW < 1 || PW < 8)
   begin : g_chk
      $error("ubl_tick_gen: widths too small");
   end

   always_comb
   begin
      nxt_pre_cnt = pre_cnt_ff;
      nxt_div_cnt = div_cnt_ff;
      nxt_tick = 1'b0;
      // R10 reload restarts
      if (reload)
      begin
         nxt_pre_cnt = prescaler - 1'b1;
         nxt_div_cnt = divisor - 1'b1;
      end
      // R9 zero divisor halts
      else if (divisor == '0 || prescaler == '0)
      begin
         nxt_pre_cnt = '0;
         nxt_div_cnt = '0;
      end
      // R3 cascade both counters
      else if (pre_cnt_ff == '0)
      begin
         nxt_pre_cnt = prescaler - 1'b1;
         if (div_cnt_ff == '0)
         begin
            nxt_div_cnt = divisor - 1'b1;
            nxt_tick = 1'b1;
         end
         else
         begin
            nxt_div_cnt = div_cnt_ff - 1'b1;
         end
      end
      else
      begin
         nxt_pre_cnt = pre_cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_cnt_ff <= '0;
         div_cnt_ff <= '0;
         tick_ff <= 1'b0;
      end
      else
      begin
         pre_cnt_ff <= nxt_pre_cnt;
         div_cnt_ff <= nxt_div_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;
endmodule : ubl_tick_gen

//--- rtl/ubl_top.sv
/*
 baud tick generator and internal loopback of one serial channel, with
 its setting registers on a plain byte register port.
 assumes the transmitter and receiver sit on sys_clk and that the
 serial line pin comes from outside the clock domain.
*/
// Local design decisions: the register addresses and the plain strobed port.
// Operation
// R1: modem control bit 4 switches loopback
// R2: loopback feeds transmit output into receiver
// R3: baud equals clock over divisor times prescaler
// R4: divisor is low byte plus 256 high
// R5: prescaler is two power exponent times sum
// R6: sample count is 16 minus register
// R7: exponent from its register, range 1-2; the code stores and shifts by any value 0-3
// R8: offset from its register, range 0-7
// R9: software avoids zero divisor or prescaler
// R10: cascaded counters, reload on setting write
`timescale 1ns/1ps
module ubl_top import ubl_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // serial line pins
   input wire logic line_rx_pin,
   output logic line_tx_pin,
   // shift register side
   input wire logic tsr_sout,
   output logic rsr_sin,
   // baud tick to transmitter and receiver
   output logic baud_tick
);
   // setting registers
   logic [7:0] modem_control_reg_ff;
   logic [SCLK_W-1:0] sample_clock_reg_ff;
   logic [7:0] divisor_low_byte_ff;
   logic [7:0] divisor_high_byte_ff;
   logic [EXP_W-1:0] prescale_exponent_ff;
   logic [OFS_W-1:0] prescale_offset_ff;
   logic reload_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [7:0] tick_cnt_ff;
   logic [7:0] nxt_modem_control_reg;
   logic [SCLK_W-1:0] nxt_sample_clock_reg;
   logic [7:0] nxt_divisor_low_byte;
   logic [7:0] nxt_divisor_high_byte;
   logic [EXP_W-1:0] nxt_prescale_exponent;
   logic [OFS_W-1:0] nxt_prescale_offset;
   logic nxt_reload;
   logic [DATA_W-1:0] nxt_rdata;
   logic [7:0] nxt_tick_cnt;
   // derived values
   logic loop_en;
   logic [SC_W-1:0] sample_count;
   logic [PRE_W-1:0] prescaler;
   logic [DIV_W-1:0] divisor;
   logic rx_pin_sync;
   logic tick;
   logic div_zero;

   function automatic logic is_setting(input logic [ADDR_W-1:0] a);
      is_setting = (a == ADDR_SAMPLE_CLK) || (a == ADDR_DIV_LOW) ||
                   (a == ADDR_DIV_HIGH) || (a == ADDR_PRE_EXP) ||
                   (a == ADDR_PRE_OFS);
   endfunction : is_setting

   // register writes and read mux
   always_comb
   begin
      nxt_modem_control_reg = modem_control_reg_ff;
      nxt_sample_clock_reg = sample_clock_reg_ff;
      nxt_divisor_low_byte = divisor_low_byte_ff;
      nxt_divisor_high_byte = divisor_high_byte_ff;
      nxt_prescale_exponent = prescale_exponent_ff;
      nxt_prescale_offset = prescale_offset_ff;
      // R10 any setting write reloads
      nxt_reload = reg_wr && is_setting(reg_addr);
      nxt_rdata = '0;
      if (reg_wr)
      begin
         case (reg_addr)
            // R1 loopback bit held here
            ADDR_MODEM_CTRL: nxt_modem_control_reg = reg_wdata;
            ADDR_SAMPLE_CLK:
               nxt_sample_clock_reg = reg_wdata[SCLK_W-1:0];
            ADDR_DIV_LOW: nxt_divisor_low_byte = reg_wdata;
            ADDR_DIV_HIGH: nxt_divisor_high_byte = reg_wdata;
            // R7 exponent stored
            ADDR_PRE_EXP:
               nxt_prescale_exponent = reg_wdata[EXP_W-1:0];
            // R8 offset stored
            ADDR_PRE_OFS:
               nxt_prescale_offset = reg_wdata[OFS_W-1:0];
            default: ;
         endcase
      end
      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_MODEM_CTRL: nxt_rdata = modem_control_reg_ff;
            ADDR_SAMPLE_CLK:
               nxt_rdata = {{(DATA_W-SCLK_W){1'b0}}, sample_clock_reg_ff};
            ADDR_DIV_LOW: nxt_rdata = divisor_low_byte_ff;
            ADDR_DIV_HIGH: nxt_rdata = divisor_high_byte_ff;
            ADDR_PRE_EXP:
               nxt_rdata = {{(DATA_W-EXP_W){1'b0}}, prescale_exponent_ff};
            ADDR_PRE_OFS:
               nxt_rdata = {{(DATA_W-OFS_W){1'b0}}, prescale_offset_ff};
            ADDR_STATUS:
            begin
               nxt_rdata[ST_LOOP_BIT] = loop_en;
               nxt_rdata[ST_DIVZ_BIT] = div_zero;
            end
            ADDR_TICK_CNT: nxt_rdata = tick_cnt_ff;
            default: nxt_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         modem_control_reg_ff <= RST_MODEM_CTRL;
         sample_clock_reg_ff <= RST_SAMPLE_CLK;
         divisor_low_byte_ff <= RST_DIV_LOW;
         divisor_high_byte_ff <= RST_DIV_HIGH;
         prescale_exponent_ff <= RST_PRE_EXP;
         prescale_offset_ff <= RST_PRE_OFS;
         reload_ff <= 1'b0;
         rdata_ff <= '0;
      end
      else
      begin
         modem_control_reg_ff <= nxt_modem_control_reg;
         sample_clock_reg_ff <= nxt_sample_clock_reg;
         divisor_low_byte_ff <= nxt_divisor_low_byte;
         divisor_high_byte_ff <= nxt_divisor_high_byte;
         prescale_exponent_ff <= nxt_prescale_exponent;
         prescale_offset_ff <= nxt_prescale_offset;
         reload_ff <= nxt_reload;
         rdata_ff <= nxt_rdata;
      end
   end

   // tick counter lets software watch the generator run
   always_comb
   begin
      nxt_tick_cnt = tick_cnt_ff;
      if (tick)
      begin
         nxt_tick_cnt = tick_cnt_ff + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tick_cnt_ff <= 8'h00;
      end
      else
      begin
         tick_cnt_ff <= nxt_tick_cnt;
      end
   end

   // R1 loopback enable bit
   assign loop_en = modem_control_reg_ff[LOOP_BIT];
   // R6 sample count from register
   assign sample_count = SC_BASE - {1'b0, sample_clock_reg_ff};
   // R5 exponent shift of the sum, widest case 23 << 3 fits 8 bits
   assign prescaler = PRE_W'({3'h0, sample_count + {2'h0,
      prescale_offset_ff}} << prescale_exponent_ff);
   // R4 divisor from both bytes
   assign divisor = {divisor_high_byte_ff, divisor_low_byte_ff};
   assign div_zero = (divisor == '0);

   ubl_sync2 u_rx_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in(line_rx_pin),
      .sync_out(rx_pin_sync)
   );

   // reload is registered so the counters load the new settings
   ubl_tick_gen #(
      .DW(DIV_W),
      .PW(PRE_W)
   ) u_baud_tick_generator (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .reload(reload_ff),
      .divisor(divisor),
      .prescaler(prescaler),
      .tick(tick)
   );

   // R2 receiver hears the transmitter
   assign rsr_sin = loop_en ? tsr_sout : rx_pin_sync;
   // pin rests idle while looped so the far end sees no frames
   assign line_tx_pin = loop_en ? LINE_IDLE : tsr_sout;
   assign reg_rdata = rdata_ff;
   assign baud_tick = tick;

   // helper: clocks since last tick or reload
   logic [PERIOD_W-1:0] gap_ff;
   logic [PERIOD_W-1:0] period;
   assign period = PERIOD_W'(divisor) * PERIOD_W'(prescaler);
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gap_ff <= '0;
      end
      // start one below zero so the first tick after a load also
      // lands on period minus one
      else if (reload_ff)
      begin
         gap_ff <= '1;
      end
      else if (tick)
      begin
         gap_ff <= '0;
      end
      else
      begin
         gap_ff <= gap_ff + 1'b1;
      end
   end

   sequence s_wr_loop_on;
      reg_wr && reg_addr == ADDR_MODEM_CTRL && reg_wdata[LOOP_BIT];
   endsequence
   sequence s_wr_loop_off;
      reg_wr && reg_addr == ADDR_MODEM_CTRL && !reg_wdata[LOOP_BIT];
   endsequence
   sequence s_setting_wr;
      reg_wr && is_setting(reg_addr);
   endsequence

   property p_loop_on;
      @(posedge sys_clk) disable iff (!rst_n)
      s_wr_loop_on |=> loop_en ##0 rsr_sin == tsr_sout;
   endproperty
   a_loop_on: assert property (p_loop_on) // R1
      else $error("loopback not enabled after write");

   property p_loop_off;
      @(posedge sys_clk) disable iff (!rst_n)
      s_wr_loop_off |=> !loop_en ##0 rsr_sin == rx_pin_sync;
   endproperty
   a_loop_off: assert property (p_loop_off) // R1
      else $error("loopback not disabled after write");

   property p_loop_route;
      @(posedge sys_clk) disable iff (!rst_n)
      loop_en |-> rsr_sin == tsr_sout && line_tx_pin == LINE_IDLE;
   endproperty
   a_loop_route: assert property (p_loop_route) // R2
      else $error("loopback path broken");

   property p_period;
      @(posedge sys_clk) disable iff (!rst_n)
      tick && !$past(reload_ff) |-> gap_ff == period - 1'b1;
   endproperty
   a_period: assert property (p_period) // R3
      else $error("tick spacing differs from divisor times prescaler");

   property p_div_form;
      @(posedge sys_clk) disable iff (!rst_n)
      reg_wr && reg_addr == ADDR_DIV_HIGH |=>
         divisor == 16'(32'($past(reg_wdata)) * 256 +
         32'(divisor_low_byte_ff));
   endproperty
   a_div_form: assert property (p_div_form) // R4
      else $error("divisor not formed from both bytes");

   property p_presc;
      @(posedge sys_clk) disable iff (!rst_n)
      prescale_exponent_ff == 2'h1 |->
         prescaler == 8'((16 - sample_clock_reg_ff +
         prescale_offset_ff) * 2);
   endproperty
   a_presc: assert property (p_presc) // R5
      else $error("prescaler value wrong");

   property p_sc;
      @(posedge sys_clk) disable iff (!rst_n)
      reg_wr && reg_addr == ADDR_SAMPLE_CLK |=>
         sample_count == 5'(16 - $past(reg_wdata[SCLK_W-1:0]));
   endproperty
   a_sc: assert property (p_sc) // R6
      else $error("sample count wrong");

   property p_exp;
      @(posedge sys_clk) disable iff (!rst_n)
      reg_wr && reg_addr == ADDR_PRE_EXP |=>
         prescale_exponent_ff == $past(reg_wdata[EXP_W-1:0]);
   endproperty
   a_exp: assert property (p_exp) // R7
      else $error("exponent not stored");

   property p_ofs;
      @(posedge sys_clk) disable iff (!rst_n)
      reg_wr && reg_addr == ADDR_PRE_OFS |=>
         prescale_offset_ff == $past(reg_wdata[OFS_W-1:0]);
   endproperty
   a_ofs: assert property (p_ofs) // R8
      else $error("offset not stored");

   property p_reload;
      @(posedge sys_clk) disable iff (!rst_n)
      s_setting_wr |=> reload_ff ##1 !tick ##0 gap_ff == '1;
   endproperty
   a_reload: assert property (p_reload) // R10
      else $error("setting write did not restart counters");

   property p_zero_halt;
      @(posedge sys_clk) disable iff (!rst_n)
      div_zero && $past(div_zero) |-> !tick;
   endproperty
   a_zero_halt: assert property (p_zero_halt) // R9
      else $error("tick with zero divisor");
endmodule : ubl_top

//--- tb/uart_baud_gen_loopback_tb_top.sv
/*
 self-checking bench for the baud tick generator and loopback block:
 register reset values and masks, tick periods, loopback switching.
 assumes ubl_pkg and the rtl modules are compiled before this file.
*/
`timescale 1ns/1ps
module uart_baud_gen_loopback_tb_top import ubl_pkg::*;
;
   logic sys_clk;
   logic rst_n;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic line_rx_pin;
   logic line_tx_pin;
   logic tsr_sout;
   logic rsr_sin;
   logic baud_tick;
   int n_mismatch;
   int num_checks;
   logic [7:0] rst_vals [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00,
      8'h02, 8'h00};

   ubl_top uut
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .line_rx_pin(line_rx_pin),
      .line_tx_pin(line_tx_pin),
      .tsr_sout(tsr_sout),
      .rsr_sin(rsr_sin),
      .baud_tick(baud_tick)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task check(input string what, input logic [31:0] seen,
      input logic [31:0] expv);
      num_checks++;
      if (seen !== expv)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %0h, seen %0h", what, expv, seen);
      end
   endtask : check

   task reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // read data stand only in the cycle after the strobe
   task reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_read

   task read_check(input logic [ADDR_W-1:0] a, input logic [7:0] expv);
      logic [7:0] d;
      reg_read(a, d);
      check($sformatf("register %0d", a), {24'h0, d}, {24'h0, expv});
   endtask : read_check

   // cycles up to and including the next tick; gives up at 3000
   task wait_tick(output int n);
      n = 0;
      do
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      while (baud_tick !== 1'b1 && n < 3000);
   endtask : wait_tick

   // period expected from the settings, not from the design
   task run_cfg(input logic [7:0] sclk, input logic [7:0] ex,
      input logic [7:0] ofs, input logic [7:0] dl, input logic [7:0] dh);
      int n;
      int period;
      logic [7:0] c0;
      logic [7:0] c1;
      period = (dl + 256 * dh) * (((16 - sclk) + ofs) * (1 << ex));
      reg_write(ADDR_SAMPLE_CLK, sclk);
      reg_write(ADDR_PRE_EXP, ex);
      reg_write(ADDR_PRE_OFS, ofs);
      reg_write(ADDR_DIV_LOW, dl);
      reg_write(ADDR_DIV_HIGH, dh);
      reg_read(ADDR_TICK_CNT, c0);
      wait_tick(n);
      wait_tick(n);
      check("tick period", n, period);
      reg_read(ADDR_TICK_CNT, c1);
      check("tick count", {24'h0, c1}, {24'h0, 8'(c0 + 8'h02)});
      $display("test period %0d done", period);
   endtask : run_cfg

   initial
   begin
      repeat (30000) @(posedge sys_clk);
      n_mismatch++;
      $display("watchdog expired");
      give_verdict();
   end

   initial
   begin
      int n;
      n_mismatch = 0;
      num_checks = 0;
      rst_n = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      line_rx_pin = 1'b1;
      tsr_sout = 1'b1;
      repeat (3) @(posedge sys_clk);
      check("tick in reset", {31'h0, baud_tick}, 32'h0);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++)
         read_check(i[2:0], rst_vals[i]);
      $display("test reset values done");
      // field masks, read-only places, halted generator
      reg_write(ADDR_SAMPLE_CLK, 8'hFF);
      read_check(ADDR_SAMPLE_CLK, 8'h0F);
      reg_write(ADDR_PRE_EXP, 8'hFF);
      read_check(ADDR_PRE_EXP, 8'h03);
      reg_write(ADDR_PRE_OFS, 8'hFF);
      read_check(ADDR_PRE_OFS, 8'h07);
      reg_write(ADDR_STATUS, 8'hFF);
      read_check(ADDR_STATUS, 8'h02);
      reg_write(ADDR_TICK_CNT, 8'h55);
      read_check(ADDR_TICK_CNT, 8'h00);
      wait_tick(n);
      check("no tick at zero divisor", n, 3000);
      $display("test masks done");
      // sample counts 4 and the largest 16, offset, exponent and high byte
      run_cfg(8'h0C, 8'h01, 8'h00, 8'h03, 8'h00);
      run_cfg(8'h0C, 8'h02, 8'h07, 8'h03, 8'h00);
      run_cfg(8'h04, 8'h02, 8'h03, 8'h05, 8'h00);
      run_cfg(8'h00, 8'h01, 8'h00, 8'h02, 8'h00);
      run_cfg(8'h0C, 8'h01, 8'h00, 8'h00, 8'h01);
      // loopback on: receiver sees the transmitter, pin idles
      reg_write(ADDR_MODEM_CTRL, 8'h10);
      read_check(ADDR_MODEM_CTRL, 8'h10);
      read_check(ADDR_STATUS, 8'h01);
      for (int v = 0; v < 2; v++)
      begin
         @(posedge sys_clk);
         tsr_sout <= v[0];
         line_rx_pin <= ~v[0];
         @(posedge sys_clk);
         #1;
         check("looped receive", {31'h0, rsr_sin}, {31'h0, v[0]});
         check("idle pin", {31'h0, line_tx_pin}, 32'h1);
      end
      $display("test loopback on done");
      // every other bit set, so only bit 4 may switch loopback
      reg_write(ADDR_MODEM_CTRL, 8'hEF);
      read_check(ADDR_STATUS, 8'h00);
      for (int v = 0; v < 2; v++)
      begin
         @(posedge sys_clk);
         tsr_sout <= v[0];
         line_rx_pin <= ~v[0];
         repeat (3) @(posedge sys_clk);
         #1;
         check("pin receive", {31'h0, rsr_sin}, {31'h0, ~v[0]});
         check("pin transmit", {31'h0, line_tx_pin}, {31'h0, v[0]});
      end
      $display("test loopback off done");
      give_verdict();
   end
endmodule : uart_baud_gen_loopback_tb_top
